// ==== logic/dme_pkg.sv ====
// Purpose: shared constants and types for the dual-mode serial EEPROM link.
// Assumes: one device end and one bus master end joined by dme_link_if.
// Notes: the device code value is arbitrary; set it alike on both ends.
// Behaviour
// - buffer up to eight bytes, program after Stop
// - data byte advances only low three pointer bits
// - over eight bytes wrap and replace buffered bytes
// - Stop after write launches self-timed programming
// - master holds write-enable clock high while writing
// - low write-enable clock blocks all programming
// - page overflow wraps within the same page
// - master keeps page writes inside one page; dme_host sends them from any start address
// - no control byte acknowledge while programming
// - master polls with write control byte
// - read control byte differs only in bit
// - current read returns byte after last access
// - random read keeps pointer from abandoned write
// - master acknowledge streams next sequential byte
// - pointer increments after every completed access
// - data line is open-drain only
// - in bidirectional mode data changes only while bus clock low
// - master keeps bus clock high for stream
// - stream bit presented on stream clock rise
// - four-bit code, three ignored bits, direction bit
// - bus clock fall enters bidirectional mode forever
// - stream MSB first, null ninth bit, wraps
// - nine silent stream clocks, data on tenth
package dme_pkg;
    localparam int DME_AW = 7; // Array address bits.
    localparam int DME_PW = 3; // Page offset bits.
    localparam int DME_SIZE = 1 << DME_AW;
    localparam int DME_PAGE = 1 << DME_PW;
    localparam int DME_PROG_CYC = 1000; // Programming time in link clocks.
    localparam int DME_QDIV = 125; // System clocks per quarter bit on the bus.
    localparam logic [3:0] DME_DEV_CODE = 4'h5; // Arbitrary value.
    localparam logic [3:0] DME_CNT_ACK = 4'h8; // Bit count of the ninth slot.
    localparam logic [3:0] DME_CNT_END = 4'h9; // Ninth slot clocked.
    localparam logic [3:0] DME_INIT_CLKS = 4'h9;
    localparam logic [3:0] DME_NULL_BIT = 4'h8;

    typedef enum logic [2:0] {
        OP_MODE,
        OP_WRITE,
        OP_READ_CUR,
        OP_READ_RND,
        OP_POLL,
        OP_TXO
    } dme_op_e;
endpackage : dme_pkg

// ==== logic/dme_link_if.sv ====
// Purpose: pins between the EEPROM device end and the bus master end.
// Assumes: the data line has a pull-up; only low levels are driven.
// Notes: the wire level is resolved here from both enables.
`timescale 1ns/1ps
`default_nettype none
interface dme_link_if;
    logic scl;
    logic vclk;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic sda;

    assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

    modport host (output scl, output vclk, output host_sda_o, output host_sda_oe, input sda);
    modport dev (input scl, input vclk, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : dme_link_if
`default_nettype wire

// ==== logic/dme_eeprom_dev.sv ====
// Purpose: device end: stream mode, two-wire slave, page buffer, programming.
// Assumes: link_clk oversamples all pins; reset stands for power-up.
// Notes: array contents are not cleared by reset.
`timescale 1ns/1ps
`default_nettype none
module dme_eeprom_dev
    import dme_pkg::*;
#(
    parameter logic [3:0] DEV_CODE = DME_DEV_CODE, // Arbitrary value.
    parameter int PROG_CYC = DME_PROG_CYC
) (
    input wire logic link_clk, // sampling clock of the link domain
    input wire logic reset, // power-up reset
    dme_link_if.dev lnk, // bus pins
    output logic bidi_mode, // high once in bidirectional mode
    output logic prog_busy // high while programming
);
    typedef enum logic [2:0] {
        D_IDLE,
        D_CTRL,
        D_ADDR,
        D_WDATA,
        D_RDATA,
        D_SKIP
    } dme_dst_e;

    localparam int CW = $clog2(PROG_CYC + 1);

    logic [7:0] mem [0:DME_SIZE-1];
    logic [7:0] pbuf [0:DME_PAGE-1];
    logic [2:0] scl_p;
    logic [2:0] sda_p;
    logic [2:0] vclk_p;
    dme_dst_e st_r;
    logic mode_r;
    logic oe_r;
    logic [3:0] cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [DME_AW-1:0] ptr_r;
    logic [3:0] init_r;
    logic [3:0] tbit_r;
    logic [DME_AW-1:0] taddr_r;
    logic busy_r;
    logic [CW-1:0] pcnt_r;
    logic [DME_PAGE-1:0] pval_r;
    logic [DME_AW-DME_PW-1:0] page_r;

    // Bit 0 of each pipe is the first synchroniser stage; bit 2 is the delayed copy.
    wire scl_hi = scl_p[1] && scl_p[2];
    wire scl_rise = scl_p[1] && !scl_p[2];
    wire scl_fall = !scl_p[1] && scl_p[2];
    wire start_c = mode_r && scl_hi && sda_p[2] && !sda_p[1];
    wire stop_c = mode_r && scl_hi && !sda_p[2] && sda_p[1];
    wire vclk_rise = vclk_p[1] && !vclk_p[2];
    wire sda_in = sda_p[1];
    wire rx_state = (st_r == D_CTRL) || (st_r == D_ADDR) || (st_r == D_WDATA);
    wire active = (st_r != D_IDLE) && (st_r != D_SKIP);
    wire ctrl_hit = (shift_r[7:4] == DEV_CODE) && !busy_r;
    wire [7:0] rd_byte = mem[ptr_r];
    wire [7:0] txo_byte = mem[taddr_r];
    wire txo_bit = txo_byte[~tbit_r[2:0]];
    wire [DME_AW-1:0] ptr_inc = ptr_r + 1'b1;
    wire [DME_PW-1:0] low_inc = ptr_r[DME_PW-1:0] + 1'b1;
    wire [DME_AW-1:0] page_inc = {ptr_r[DME_AW-1:DME_PW], low_inc};
    wire wr_ev = mode_r && scl_fall && (cnt_r == DME_CNT_ACK) && (st_r == D_WDATA);
    wire prog_done = busy_r && (pcnt_r == CW'(1));
    wire launch = stop_c && (|pval_r) && vclk_p[1];

    assign lnk.dev_sda_o = 1'b0;
    assign lnk.dev_sda_oe = oe_r;
    assign bidi_mode = mode_r;
    assign prog_busy = busy_r;

    always_ff @(posedge link_clk) begin
        if (reset) begin
            scl_p <= 3'h7;
            sda_p <= 3'h7;
            vclk_p <= 3'h7;
        end else begin
            scl_p <= {scl_p[1:0], lnk.scl};
            sda_p <= {sda_p[1:0], lnk.sda};
            vclk_p <= {vclk_p[1:0], lnk.vclk};
        end
    end

    always_ff @(posedge link_clk) begin
        if (reset) begin
            mode_r <= 1'b0;
            oe_r <= 1'b0;
            st_r <= D_IDLE;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= '0;
            init_r <= 4'h0;
            tbit_r <= 4'h0;
            taddr_r <= '0;
        end else if (!mode_r) begin
            if (scl_fall) begin
                mode_r <= 1'b1;
                oe_r <= 1'b0;
                st_r <= D_IDLE;
                cnt_r <= 4'h0;
            end else if (vclk_rise) begin
                if (init_r != DME_INIT_CLKS) begin
                    init_r <= init_r + 4'h1;
                end else if (tbit_r == DME_NULL_BIT) begin
                    oe_r <= 1'b0;
                    tbit_r <= 4'h0;
                    taddr_r <= taddr_r + 1'b1;
                end else begin
                    oe_r <= !txo_bit;
                    tbit_r <= tbit_r + 4'h1;
                end
            end
        end else if (start_c) begin
            st_r <= D_CTRL;
            cnt_r <= 4'h0;
            oe_r <= 1'b0;
        end else if (stop_c) begin
            st_r <= D_IDLE;
            cnt_r <= 4'h0;
            oe_r <= 1'b0;
        end else if (scl_rise && active) begin
            if (cnt_r < DME_CNT_ACK) begin
                shift_r <= {shift_r[6:0], sda_in};
                cnt_r <= cnt_r + 4'h1;
            end else if (cnt_r == DME_CNT_ACK && st_r == D_RDATA) begin
                if (!sda_in) begin
                    tx_r <= rd_byte;
                    ptr_r <= ptr_inc;
                    cnt_r <= DME_CNT_END;
                end else begin
                    st_r <= D_SKIP;
                    cnt_r <= 4'h0;
                end
            end
        end else if (scl_fall && active) begin
            if (cnt_r == DME_CNT_END) begin
                oe_r <= (st_r == D_RDATA) && !tx_r[7];
                cnt_r <= 4'h0;
            end else if (st_r == D_RDATA) begin
                if (cnt_r == DME_CNT_ACK) begin
                    oe_r <= 1'b0;
                end else if (cnt_r != 4'h0) begin
                    oe_r <= !tx_r[6];
                    tx_r <= {tx_r[6:0], 1'b0};
                end
            end else if (cnt_r == DME_CNT_ACK && rx_state) begin
                cnt_r <= DME_CNT_END;
                unique case (st_r)
                    D_CTRL: begin
                        if (!ctrl_hit) begin
                            st_r <= D_SKIP;
                            cnt_r <= 4'h0;
                        end else if (shift_r[0]) begin
                            st_r <= D_RDATA;
                            oe_r <= 1'b1;
                            tx_r <= rd_byte;
                            ptr_r <= ptr_inc;
                        end else begin
                            st_r <= D_ADDR;
                            oe_r <= 1'b1;
                        end
                    end
                    D_ADDR: begin
                        ptr_r <= shift_r[DME_AW-1:0];
                        st_r <= D_WDATA;
                        oe_r <= 1'b1;
                    end
                    D_WDATA: begin
                        ptr_r <= page_inc;
                        oe_r <= 1'b1;
                    end
                    default: begin
                        oe_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (wr_ev) begin
            pbuf[ptr_r[DME_PW-1:0]] <= shift_r;
        end
    end

    always_ff @(posedge link_clk) begin
        if (reset) begin
            busy_r <= 1'b0;
            pcnt_r <= '0;
            pval_r <= '0;
            page_r <= '0;
        end else if (busy_r) begin
            pcnt_r <= pcnt_r - CW'(1);
            if (prog_done) begin
                busy_r <= 1'b0;
                pval_r <= '0;
            end
        end else if (launch) begin
            busy_r <= 1'b1;
            pcnt_r <= CW'(PROG_CYC);
            page_r <= ptr_r[DME_AW-1:DME_PW];
        end else if (stop_c || start_c) begin
            pval_r <= '0;
        end else if (wr_ev) begin
            pval_r[ptr_r[DME_PW-1:0]] <= 1'b1;
        end
    end

    // Only buffered positions are written; the rest of the page keeps its data.
    always_ff @(posedge link_clk) begin
        if (prog_done) begin
            for (int i = 0; i < DME_PAGE; i++) begin
                if (pval_r[i]) begin
                    mem[{page_r, DME_PW'(i)}] <= pbuf[i];
                end
            end
        end
    end
endmodule : dme_eeprom_dev
`default_nettype wire

// ==== logic/dme_host.sv ====
// Purpose: bus master end: mode switch, writes, reads, polling, stream clocking.
// Assumes: user logic on sys_clk; one command at a time.
// Notes: bus clock and stream clock are derived from sys_clk by QDIV.
`timescale 1ns/1ps
`default_nettype none
module dme_host
    import dme_pkg::*;
#(
    parameter logic [3:0] DEV_CODE = DME_DEV_CODE, // Arbitrary value.
    parameter int QDIV = DME_QDIV
) (
    input wire logic sys_clk, // system clock
    input wire logic reset, // synchronous reset
    dme_link_if.host lnk, // bus pins
    input wire logic cmd_valid, // command request
    output logic cmd_ready, // command accepted when high with valid
    input wire dme_op_e cmd_op, // operation
    input wire logic [6:0] cmd_addr, // word address
    input wire logic [2:0] cmd_len, // byte count minus one
    input wire logic [63:0] cmd_wdata, // write bytes, first in low byte
    input wire logic wp, // write protect request
    output logic done, // command finished
    output logic done_ack, // every byte acknowledged
    output logic rd_valid, // read byte strobe
    output logic [7:0] rd_data // read byte
);
    typedef enum logic [3:0] {
        H_IDLE,
        H_MODE,
        H_START,
        H_CTRL,
        H_ADDR,
        H_WDATA,
        H_RDATA,
        H_STOP,
        H_TXO
    } dme_hst_e;

    localparam int DW = $clog2(QDIV);

    dme_hst_e st_r;
    dme_op_e op_r;
    logic [DW-1:0] div_r;
    logic [1:0] q_r;
    logic [3:0] bc_r;
    logic [2:0] nb_r;
    logic [2:0] len_r;
    logic [6:0] addr_r;
    logic [63:0] wd_r;
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    logic [1:0] sda_p;
    logic rdph_r;
    logic nak_r;
    logic scl_r;
    logic vclk_r;
    logic oe_r;
    logic ack_r;
    logic done_r;
    logic rdv_r;
    logic [7:0] rdd_r;
    logic rdy_r;

    wire tick = div_r == DW'(QDIV - 1);
    wire sda_in = sda_p[1];
    wire accept = cmd_valid && rdy_r;
    wire more = nb_r != len_r;
    wire rw = (op_r == OP_READ_CUR) || rdph_r;
    wire byte_end = (q_r == 2'h3) && (bc_r == DME_CNT_ACK);
    wire dme_hst_e first_st = (cmd_op == OP_MODE) ? H_MODE : (cmd_op == OP_TXO) ? H_TXO : H_START;

    assign lnk.scl = scl_r;
    assign lnk.vclk = vclk_r;
    assign lnk.host_sda_o = 1'b0;
    assign lnk.host_sda_oe = oe_r;
    assign cmd_ready = rdy_r;
    assign done = done_r;
    assign done_ack = ack_r;
    assign rd_valid = rdv_r;
    assign rd_data = rdd_r;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sda_p <= 2'h3;
            div_r <= '0;
        end else begin
            sda_p <= {sda_p[0], lnk.sda};
            div_r <= (tick || accept) ? '0 : div_r + DW'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r <= H_IDLE;
            op_r <= OP_MODE;
            q_r <= 2'h0;
            bc_r <= 4'h0;
            nb_r <= 3'h0;
            len_r <= 3'h0;
            addr_r <= 7'h00;
            wd_r <= 64'h0;
            tx_r <= 8'h00;
            rx_r <= 8'h00;
            rdph_r <= 1'b0;
            nak_r <= 1'b0;
            scl_r <= 1'b1;
            vclk_r <= 1'b1;
            oe_r <= 1'b0;
            ack_r <= 1'b1;
            done_r <= 1'b0;
            rdv_r <= 1'b0;
            rdd_r <= 8'h00;
            rdy_r <= 1'b1;
        end else begin
            done_r <= 1'b0;
            rdv_r <= 1'b0;
            if (st_r == H_IDLE) begin
                vclk_r <= !wp;
                if (accept) begin
                    st_r <= first_st;
                    op_r <= cmd_op;
                    addr_r <= cmd_addr;
                    len_r <= cmd_len;
                    wd_r <= cmd_wdata;
                    rdy_r <= 1'b0;
                    q_r <= 2'h0;
                    bc_r <= 4'h0;
                    nb_r <= 3'h0;
                    rdph_r <= 1'b0;
                    nak_r <= 1'b0;
                    ack_r <= 1'b1;
                end
            end else if (tick) begin
                q_r <= q_r + 2'h1;
                unique case (st_r)
                    H_MODE: begin
                        scl_r <= (q_r != 2'h0);
                    end
                    H_START: begin
                        if (q_r == 2'h0) oe_r <= 1'b0;
                        if (q_r == 2'h1) scl_r <= 1'b1;
                        if (q_r == 2'h2) oe_r <= 1'b1;
                        if (q_r == 2'h3) begin
                            scl_r <= 1'b0;
                            st_r <= H_CTRL;
                            tx_r <= {DEV_CODE, 3'h0, rw};
                        end
                    end
                    H_CTRL, H_ADDR, H_WDATA: begin
                        if (q_r == 2'h0) oe_r <= (bc_r != DME_CNT_ACK) && !tx_r[7];
                        if (q_r == 2'h1) scl_r <= 1'b1;
                        if (q_r == 2'h2 && bc_r == DME_CNT_ACK) begin
                            nak_r <= sda_in;
                            if (sda_in) ack_r <= 1'b0;
                        end
                        if (q_r == 2'h3) begin
                            scl_r <= 1'b0;
                            tx_r <= {tx_r[6:0], 1'b0};
                            bc_r <= bc_r + 4'h1;
                        end
                    end
                    H_RDATA: begin
                        if (q_r == 2'h0) oe_r <= (bc_r == DME_CNT_ACK) && more;
                        if (q_r == 2'h1) scl_r <= 1'b1;
                        if (q_r == 2'h2 && bc_r != DME_CNT_ACK) rx_r <= {rx_r[6:0], sda_in};
                        if (q_r == 2'h3) begin
                            scl_r <= 1'b0;
                            bc_r <= bc_r + 4'h1;
                        end
                    end
                    H_STOP: begin
                        if (q_r == 2'h0) oe_r <= 1'b1;
                        if (q_r == 2'h1) scl_r <= 1'b1;
                        if (q_r == 2'h2) oe_r <= 1'b0;
                    end
                    H_TXO: begin
                        if (q_r == 2'h0) vclk_r <= 1'b0;
                        if (q_r == 2'h1) vclk_r <= 1'b1;
                        if (q_r == 2'h3) begin
                            rdd_r <= {7'h00, sda_in};
                            rdv_r <= 1'b1;
                        end
                    end
                    default: begin
                        st_r <= H_IDLE;
                    end
                endcase
                if (q_r == 2'h3 && (st_r == H_MODE || st_r == H_STOP || st_r == H_TXO)) begin
                    st_r <= H_IDLE;
                    done_r <= 1'b1;
                    rdy_r <= 1'b1;
                end
                if (byte_end) begin
                    bc_r <= 4'h0;
                    if (st_r == H_RDATA) begin
                        rdv_r <= 1'b1;
                        rdd_r <= rx_r;
                        nb_r <= nb_r + 3'h1;
                        if (!more) st_r <= H_STOP;
                    end else if (nak_r) begin
                        st_r <= H_STOP;
                    end else if (st_r == H_CTRL) begin
                        if (rw) st_r <= H_RDATA;
                        else if (op_r == OP_POLL) st_r <= H_STOP;
                        else st_r <= H_ADDR;
                        tx_r <= {1'b0, addr_r};
                    end else if (st_r == H_ADDR && op_r == OP_READ_RND) begin
                        rdph_r <= 1'b1;
                        st_r <= H_START;
                    end else if (st_r == H_ADDR || more) begin
                        st_r <= H_WDATA;
                        tx_r <= wd_r[7:0];
                        wd_r <= {8'h00, wd_r[63:8]};
                        if (st_r == H_WDATA) nb_r <= nb_r + 3'h1;
                    end else begin
                        st_r <= H_STOP;
                    end
                end
            end
        end
    end
endmodule : dme_host
`default_nettype wire

// ==== tb/dme_link_checker.sv ====
// Purpose: assertions on the link pins and device flags.
// Assumes: one link_clk domain; reset is the device reset.
// Notes: PROG_CYC must match the device instance.
`timescale 1ns/1ps
`default_nettype none
module dme_link_checker #(
    parameter int PROG_CYC = dme_pkg::DME_PROG_CYC
) (
    input wire logic link_clk, // device clock
    input wire logic reset, // device reset
    input wire logic scl, // bus clock
    input wire logic vclk, // stream clock
    input wire logic sda, // resolved line
    input wire logic dev_sda_o, // device data level
    input wire logic dev_sda_oe, // device pull enable
    input wire logic bidi_mode, // mode flag
    input wire logic prog_busy // programming flag
);
    logic [15:0] busy_cnt_r;
    logic [3:0] vrise_r;
    wire logic vrise_sat = (vrise_r == 4'hf);
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (reset);
    // Counts busy cycles and raw stream clock rises for the bounds below.
    always_ff @(posedge link_clk) begin
        if (reset) begin
            busy_cnt_r <= 16'h0;
            vrise_r <= 4'h0;
        end else begin
            busy_cnt_r <= prog_busy ? busy_cnt_r + 16'h1 : 16'h0;
            vrise_r <= ($rose(vclk) && !vrise_sat) ? vrise_r + 4'h1 : vrise_r;
        end
    end
    a_open_drain: assert property (dev_sda_o == 1'b0 && (!dev_sda_oe || !sda))
        else $error("device drives the data line high");
    a_oe_scl_low: assert property (bidi_mode && $changed(dev_sda_oe) |-> !scl)
        else $error("device data changed while bus clock high");
    a_busy_silent: assert property (prog_busy |-> !dev_sda_oe)
        else $error("device answered while programming");
    a_busy_len: assert property ($fell(prog_busy) |-> busy_cnt_r == 16'(PROG_CYC))
        else $error("programming time wrong");
    a_busy_bound: assert property (prog_busy |-> busy_cnt_r < 16'(PROG_CYC))
        else $error("programming overran");
    a_busy_at_stop: assert property ($rose(prog_busy) |-> scl && sda && vclk)
        else $error("programming started without stop or with protect");
    a_mode_enter: assert property ($fell(scl) |-> ##[1:6] bidi_mode)
        else $error("bus clock fall did not switch mode");
    a_mode_stay: assert property (bidi_mode |=> bidi_mode)
        else $error("bidirectional mode left");
    a_stream_quiet: assert property (!bidi_mode && vrise_r < 4'ha |-> !dev_sda_oe)
        else $error("data driven during init clocks");
    a_stream_on_rise: assert property (!bidi_mode && $changed(dev_sda_oe) |-> vclk)
        else $error("stream bit changed outside clock high");
endmodule : dme_link_checker
`default_nettype wire

// ==== tb/dual_mode_serial_eeprom_access_tb_top.sv ====
// Purpose: host and device ends joined over one link, driven by commands.
// Assumes: QDIV 45 and PROG_CYC 200 keep the run short.
// Notes: array locations are read only after being written.
`timescale 1ns/1ps
`default_nettype none
module dual_mode_serial_eeprom_access_tb_top import dme_pkg::*; ;
    logic sys_clk, link_clk, reset, dev_reset, cmd_valid, cmd_ready, wp, done, done_ack;
    logic rd_valid, bidi_mode, prog_busy;
    dme_op_e cmd_op;
    logic [6:0] cmd_addr;
    logic [2:0] cmd_len;
    logic [63:0] cmd_wdata;
    logic [7:0] rd_data;
    logic [7:0] rq[$];
    int n_mismatch = 0;
    int samples_checked = 0;
    localparam logic [7:0] LOC0_DATA = 8'h5a; // Last value programmed at location zero.
    dme_link_if lnk_if();
    dme_eeprom_dev #(.PROG_CYC(200)) dme_eeprom_dev_inst (.link_clk(link_clk), .reset(dev_reset),
        .lnk(lnk_if), .bidi_mode(bidi_mode), .prog_busy(prog_busy));
    dme_host #(.QDIV(45)) dme_host_inst (.sys_clk(sys_clk), .reset(reset), .lnk(lnk_if),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_len(cmd_len), .cmd_wdata(cmd_wdata), .wp(wp), .done(done), .done_ack(done_ack),
        .rd_valid(rd_valid), .rd_data(rd_data));
    dme_link_checker #(.PROG_CYC(200)) dme_link_checker_inst (.link_clk(link_clk), .reset(dev_reset),
        .scl(lnk_if.scl), .vclk(lnk_if.vclk), .sda(lnk_if.sda), .dev_sda_o(lnk_if.dev_sda_o),
        .dev_sda_oe(lnk_if.dev_sda_oe), .bidi_mode(bidi_mode), .prog_busy(prog_busy));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        link_clk = 1'b0;
        #13;
        forever #40 link_clk = ~link_clk;
    end
    always @(posedge sys_clk) begin
        if (rd_valid === 1'b1) rq.push_back(rd_data);
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic run(input dme_op_e op, input logic [6:0] a, input logic [2:0] n, input logic [63:0] d);
        int i;
        rq.delete();
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_len <= n;
        cmd_wdata <= d;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        @(posedge sys_clk);
        chk("ready while busy", {7'h0, cmd_ready}, 8'h00);
        for (i = 0; i < 30000 && done !== 1'b1; i++) @(posedge sys_clk);
        chk("done", {7'h0, done}, 8'h01);
        chk("ready after done", {7'h0, cmd_ready}, 8'h01);
    endtask : run
    task automatic poll_wait();
        int i;
        for (i = 0; i < 6; i++) begin
            run(OP_POLL, 7'h0, 3'h0, 64'h0);
            if (done_ack === 1'b1) break;
        end
        chk("poll answer", {7'h0, done_ack}, 8'h01);
    endtask : poll_wait
    task automatic end_of_test();
        $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (95000) @(posedge sys_clk);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        reset = 1'b1;
        dev_reset = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = OP_MODE;
        cmd_addr = 7'h0;
        cmd_len = 3'h0;
        cmd_wdata = 64'h0;
        wp = 1'b0;
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (20) @(posedge link_clk);
        dev_reset <= 1'b0;
        for (int k = 0; k < 9; k++) begin
            run(OP_TXO, 7'h0, 3'h0, 64'h0);
            chk("stream init bit", {7'h0, rd_data[0]}, 8'h01);
        end
        chk("mode before switch", {7'h0, bidi_mode}, 8'h00);
        run(OP_MODE, 7'h0, 3'h0, 64'h0);
        repeat (40) @(posedge sys_clk);
        chk("mode after switch", {7'h0, bidi_mode}, 8'h01);
        // Eight bytes from 7d must wrap onto 78..7c of the same page.
        run(OP_WRITE, 7'h7d, 3'h7, 64'h1716151413121110);
        chk("page write ack", {7'h0, done_ack}, 8'h01);
        run(OP_POLL, 7'h0, 3'h0, 64'h0);
        chk("poll while busy", {7'h0, done_ack}, 8'h00);
        poll_wait();
        run(OP_READ_CUR, 7'h0, 3'h0, 64'h0);
        chk("current read", rq[0], 8'h10);
        run(OP_READ_CUR, 7'h0, 3'h0, 64'h0);
        chk("next current read", rq[0], 8'h11);
        run(OP_READ_RND, 7'h78, 3'h0, 64'h0);
        chk("wrapped page byte", rq[0], 8'h13);
        run(OP_WRITE, 7'h00, 3'h0, {56'h0, LOC0_DATA});
        poll_wait();
        @(posedge sys_clk);
        wp <= 1'b1;
        repeat (4) @(posedge sys_clk);
        run(OP_WRITE, 7'h00, 3'h0, 64'ha5);
        repeat (200) @(posedge sys_clk);
        chk("protected write busy", {7'h0, prog_busy}, 8'h00);
        wp <= 1'b0;
        run(OP_READ_RND, 7'h7f, 3'h1, 64'h0);
        chk("read last location", rq[0], 8'h12);
        chk("read wrapped to zero", rq[1], LOC0_DATA);
        // Power cycle the device end: nine silent clocks, then location zero MSB first and a null bit.
        @(posedge link_clk);
        dev_reset <= 1'b1;
        repeat (4) @(posedge link_clk);
        dev_reset <= 1'b0;
        repeat (4) @(posedge link_clk);
        for (int k = 0; k < 18; k++) begin
            run(OP_TXO, 7'h0, 3'h0, 64'h0);
            chk("stream bit", {7'h0, rd_data[0]}, {7'h0, (k > 8 && k < 17) ? LOC0_DATA[16 - k] : 1'b1});
        end
        end_of_test();
    end
endmodule : dual_mode_serial_eeprom_access_tb_top
`default_nettype wire
